// [design/pdsc_divider.v]
// Purpose: clock divider stepped by an enable tick, separate high and low lengths
// Assumes: tick is a one-cycle pulse in the clk domain
// Notes: equal high and low lengths give an exact 50% duty cycle
`timescale 1ns/10ps
`default_nettype none

module pdsc_divider (
   input  wire       clk,
   input  wire       rst_n,
   input  wire       tick,
   input  wire [7:0] high_len,
   input  wire [7:0] low_len,
   output reg        div_out
);

   reg  [7:0] count;
   wire [7:0] cur_len;
   wire [7:0] next_count;

   // zero length would stall the divider, treat as one
   assign cur_len    = div_out ? ((high_len == 8'h00) ? 8'h01 : high_len)
                               : ((low_len == 8'h00) ? 8'h01 : low_len);
   assign next_count = count + 8'h01;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count   <= 8'h00;
         div_out <= 1'b0;
      end else if (tick) begin
         if (next_count >= cur_len) begin
            count   <= 8'h00;
            div_out <= ~div_out;
         end else begin
            count <= next_count;
         end
      end
   end

endmodule

`default_nettype wire

// [design/pdsc_top.v]
// Purpose: serial divider programming, reference select, bypass and dividers of a
//          clock multiplier, with an Avalon-MM register view
// Assumes: all pins synchronous to clk; the loop oscillator is modelled as one tick per clk
// Notes: reference and feedback clocks are sampled levels, so they must stay well below clk/2
`timescale 1ns/10ps
`default_nettype none
`include "pdsc_defs.vh"

// What this block does
// - with the load strobe low, every rising shift clock edge shifts serial data into the shift word.
// - a rising load strobe copies the shift word into the pre, output and feedback divider settings.
// - a falling load strobe freezes the divider settings until the next transfer.
// - with the load strobe high, each rising shift clock edge passes the shifted data straight into the settings.
// - reference select low picks the single-ended reference, high picks the differential pair.
// - bypass low feeds the output divider from the oscillator, high from the selected reference.
// - the output divider produces a clock of 50% duty cycle for every ratio.
// - with control bit 1 clear, the feedback divider output goes to the phase detector that judges lock against the reference.
// - the main and feedback outputs both carry the output divider clock.
// - unconnected control inputs read low, except reference select which reads high.
// - pre-divider code 00, 01, 10, 11 divides by 1, 2, 4, 8.
// - output divider code is half the output divide ratio.
// - feedback divider code is the feedback divide ratio itself.
module pdsc_top (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        load_strobe,
   input  wire        serial_data,
   input  wire        shift_clock,
   input  wire        ref_select,
   input  wire        bypass,
   input  wire        single_ended_ref,
   input  wire        diff_ref_positive,
   input  wire        diff_ref_negative,
   input  wire        feedback_return_pos,
   input  wire        feedback_return_neg,
   output reg         main_out,
   output reg         main_out_n,
   output reg         feedback_output,
   output reg         feedback_output_n,
   output reg         locked,
   input  wire [3:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest
);

   // ----------------------------------------------------------------
   // pin sampling
   // ----------------------------------------------------------------
   reg                       load_q;
   reg                       sdata_q;
   reg                       sclk_q;
   reg                       sclk_d;
   reg                       sel_q;
   reg                       bypass_q;
   reg                       se_q;
   reg                       diff_lvl;
   reg                       fbret_lvl;
   reg                       ref_d;
   reg                       fbret_d;

   // pull levels stand in until the first sample
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         load_q   <= 1'b0;
         sdata_q  <= 1'b0;
         sclk_q   <= 1'b0;
         sclk_d   <= 1'b0;
         sel_q    <= 1'b1;
         bypass_q <= 1'b0;
         se_q     <= 1'b0;
      end else begin
         load_q   <= load_strobe;
         sdata_q  <= serial_data;
         sclk_q   <= shift_clock;
         sclk_d   <= sclk_q;
         sel_q    <= ref_select;
         bypass_q <= bypass;
         se_q     <= single_ended_ref;
      end
   end

   // differential receivers hold their level while both legs are equal
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         diff_lvl  <= 1'b0;
         fbret_lvl <= 1'b0;
      end else begin
         if (diff_ref_positive != diff_ref_negative) begin
            diff_lvl <= diff_ref_positive;
         end
         if (feedback_return_pos != feedback_return_neg) begin
            fbret_lvl <= feedback_return_pos;
         end
      end
   end

   wire ref_lvl   = sel_q ? diff_lvl : se_q;
   wire ref_tick  = ref_lvl & ~ref_d;
   wire fbret_tick = fbret_lvl & ~fbret_d;
   wire sclk_rise = sclk_q & ~sclk_d;

   // ----------------------------------------------------------------
   // serial programming
   // ----------------------------------------------------------------
   reg  [`PDSC_SHIFT_W-1:0]  shift_word;
   reg  [1:0]                pre_code;
   reg  [6:0]                out_code;
   reg  [4:0]                fb_code;
   reg                       load_d;
   reg                       frozen;
   wire [`PDSC_SHIFT_W-1:0]  next_shift = {shift_word[`PDSC_SHIFT_W-2:0], sdata_q};
   wire                      load_rise  = load_q & ~load_d;
   wire                      load_fall  = ~load_q & load_d;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_word <= {`PDSC_SHIFT_W{1'b0}};
         pre_code   <= `PDSC_PRE_RST;
         out_code   <= `PDSC_OUT_RST;
         fb_code    <= `PDSC_FB_RST;
         load_d     <= 1'b0;
         frozen     <= 1'b1;
      end else begin
         load_d <= load_q;
         if (sclk_rise) begin
            shift_word <= next_shift;
         end
         if (load_q && sclk_rise) begin
            pre_code <= next_shift[`PDSC_PRE_MSB:`PDSC_PRE_LSB];
            out_code <= next_shift[`PDSC_OUT_MSB:`PDSC_OUT_LSB];
            fb_code  <= next_shift[`PDSC_FB_MSB:`PDSC_FB_LSB];
         end else if (load_rise) begin
            pre_code <= shift_word[`PDSC_PRE_MSB:`PDSC_PRE_LSB];
            out_code <= shift_word[`PDSC_OUT_MSB:`PDSC_OUT_LSB];
            fb_code  <= shift_word[`PDSC_FB_MSB:`PDSC_FB_LSB];
         end
         if (load_fall) begin
            frozen <= 1'b1;
         end else if (load_rise) begin
            frozen <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // reference pre-divider
   // ----------------------------------------------------------------
   reg  [2:0] pre_count;
   reg        pre_tick;
   wire [2:0] pre_last = (3'h1 << pre_code) - 3'h1;
   reg  [1:0] ctrl;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_d     <= 1'b0;
         fbret_d   <= 1'b0;
         pre_count <= 3'h0;
         pre_tick  <= 1'b0;
      end else begin
         ref_d    <= ref_lvl;
         fbret_d  <= fbret_lvl;
         pre_tick <= 1'b0;
         if (ref_tick) begin
            if (pre_count >= pre_last) begin
               pre_count <= 3'h0;
               pre_tick  <= 1'b1;
            end else begin
               pre_count <= pre_count + 3'h1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // output and feedback dividers
   // ----------------------------------------------------------------
   wire       vco_tick = 1'b1;
   wire       out_src  = bypass_q ? ref_tick : vco_tick;
   wire       out_clk;
   wire       fb_clk;
   wire [7:0] fb_high  = {3'h0, fb_code} - {4'h0, fb_code[4:1]};
   wire [7:0] fb_low   = {4'h0, fb_code[4:1]};

   // equal high and low lengths of the code give ratio 2*code at 50%
   pdsc_divider u_out_div (
      .clk      (clk),
      .rst_n    (rst_n),
      .tick     (out_src),
      .high_len ({1'b0, out_code}),
      .low_len  ({1'b0, out_code}),
      .div_out  (out_clk)
   );

   // odd feedback ratios put the extra tick in the high phase
   pdsc_divider u_fb_div (
      .clk      (clk),
      .rst_n    (rst_n),
      .tick     (vco_tick),
      .high_len (fb_high),
      .low_len  (fb_low),
      .div_out  (fb_clk)
   );

   // ----------------------------------------------------------------
   // phase detector and lock
   // ----------------------------------------------------------------
   reg        fb_d;
   reg  [1:0] phase_err;
   reg  [7:0] lock_count;
   wire       fb_int_tick = fb_clk & ~fb_d;
   wire       pd_fb_tick  = ctrl[`PDSC_CTRL_EXT_FB] ? fbret_tick : fb_int_tick;

   // a sustained surplus on either side means the ratio cannot lock
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fb_d       <= 1'b0;
         phase_err  <= 2'h0;
         lock_count <= 8'h00;
         locked     <= 1'b0;
      end else begin
         fb_d <= fb_clk;
         if (pre_tick && !pd_fb_tick) begin
            if (phase_err == 2'h1) begin
               lock_count <= 8'h00;
               locked     <= 1'b0;
            end else begin
               phase_err <= phase_err + 2'h1;
               if (lock_count >= `PDSC_LOCK_EDGES) begin
                  locked <= 1'b1;
               end else begin
                  lock_count <= lock_count + 8'h01;
               end
            end
         end else if (pd_fb_tick && !pre_tick) begin
            if (phase_err == 2'h3) begin
               lock_count <= 8'h00;
               locked     <= 1'b0;
            end else begin
               phase_err <= phase_err - 2'h1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // output stage
   // ----------------------------------------------------------------
   wire out_level = out_clk & ctrl[`PDSC_CTRL_OUT_EN];

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         main_out          <= 1'b0;
         main_out_n        <= 1'b1;
         feedback_output   <= 1'b0;
         feedback_output_n <= 1'b1;
      end else begin
         main_out          <= out_level;
         main_out_n        <= ~out_level;
         feedback_output   <= out_level;
         feedback_output_n <= ~out_level;
      end
   end

   // ----------------------------------------------------------------
   // register bus, one wait state on every access
   // ----------------------------------------------------------------
   wire req = avs_read | avs_write;
   reg  [31:0] next_readdata;

   always @* begin
      next_readdata = 32'h0000_0000;
      case (avs_address)
         `PDSC_REG_CONFIG:  next_readdata = {18'h0, pre_code, out_code, fb_code};
         `PDSC_REG_SHIFT:   next_readdata = {18'h0, shift_word};
         `PDSC_REG_STATUS:  next_readdata = {26'h0, frozen, load_q, sel_q, bypass_q,
                                            phase_err == 2'h0, locked};
         `PDSC_REG_CONTROL: next_readdata = {30'h0, ctrl};
         default:           next_readdata = 32'h0000_0000;
      endcase
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
         ctrl            <= `PDSC_CTRL_RST;
      end else begin
         if (req && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= avs_read ? next_readdata : 32'h0000_0000;
         end else begin
            avs_waitrequest <= 1'b1;
         end
         if (avs_write && !avs_waitrequest && avs_address == `PDSC_REG_CONTROL) begin
            ctrl <= avs_writedata[1:0];
         end
      end
   end

endmodule

`default_nettype wire

// [pkg/pdsc_defs.vh]
// Purpose: shared constants of the serially programmed clock multiplier control
// Assumes: included by bare name from the design files
// Notes: offsets are byte addresses on the register bus
`ifndef PDSC_DEFS_VH
`define PDSC_DEFS_VH

// ----------------------------------------------------------------
// shift word layout
// ----------------------------------------------------------------
`define PDSC_SHIFT_W        14
`define PDSC_PRE_MSB        13
`define PDSC_PRE_LSB        12
`define PDSC_OUT_MSB        11
`define PDSC_OUT_LSB        5
`define PDSC_FB_MSB         4
`define PDSC_FB_LSB         0

// ----------------------------------------------------------------
// reset values of the divider settings and the control register
// ----------------------------------------------------------------
`define PDSC_PRE_RST        2'h0
`define PDSC_OUT_RST        7'h05
`define PDSC_FB_RST         5'h0c
`define PDSC_CTRL_RST       2'h1

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define PDSC_ADDR_W         4
`define PDSC_REG_CONFIG     4'h0
`define PDSC_REG_SHIFT      4'h4
`define PDSC_REG_STATUS     4'h8
`define PDSC_REG_CONTROL    4'hc
`define PDSC_CTRL_OUT_EN    0
`define PDSC_CTRL_EXT_FB    1

// ----------------------------------------------------------------
// lock detection
// ----------------------------------------------------------------
`define PDSC_LOCK_EDGES     8'h10

`endif

// [verification/pdsc_host_model.sv]
// Purpose: host programmer on the three-wire serial pins
// Assumes: tasks are entered just after a rising clk edge
// Notes: serial data and shift clock levels are held 4 clk and the load strobe 8, above the 3 the sampler needs
`timescale 1ns/10ps
`default_nettype none
module pdsc_host_model (
   input  wire logic clk,
   output var logic  load_strobe,
   output var logic  serial_data,
   output var logic  shift_clock
);
   initial begin
      load_strobe = 1'b0;
      serial_data = 1'b0;
      shift_clock = 1'b0;
   end
   task automatic hold();
      repeat (4) @(posedge clk);
   endtask
   // data set well before the rise and kept past the fall
   task automatic shift_bit(input logic b);
      serial_data <= b;
      hold();
      shift_clock <= 1'b1;
      hold();
      shift_clock <= 1'b0;
      hold();
   endtask
   task automatic send_word(input logic [13:0] w);
      for (int i = 13; i >= 0; i--) shift_bit(w[i]);
   endtask
   task automatic set_load(input logic v);
      load_strobe <= v;
      repeat (8) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// [verification/pdsc_properties.sv]
// Purpose: port-level properties of the divider control block
// Assumes: one clock domain, asynchronous active-low reset
// Notes: duty checking pauses while settings or bypass may move
`timescale 1ns/10ps
`default_nettype none
`include "pdsc_defs.vh"
module pdsc_checker (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        load_strobe,
   input wire logic        ref_select,
   input wire logic        bypass,
   input wire logic        single_ended_ref,
   input wire logic        diff_ref_positive,
   input wire logic        diff_ref_negative,
   input wire logic        main_out,
   input wire logic        main_out_n,
   input wire logic        feedback_output,
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest
);
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [7:0] cnt;
   logic [7:0] hi_len;
   logic       seen_rise;
   logic       hi_ok;
   logic       out_en;
   logic [2:0] en_hist;
   wire        pause = load_strobe | bypass | avs_write | ~&en_hist;
   // ----
   // run lengths of main_out
   // ----
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 8'h00;
         hi_len <= 8'h00;
         seen_rise <= 1'b0;
         hi_ok <= 1'b0;
      end else if (pause) begin
         cnt <= 8'h00;
         seen_rise <= 1'b0;
         hi_ok <= 1'b0;
      end else if ($fell(main_out)) begin
         hi_len <= cnt;
         hi_ok <= seen_rise;
         cnt <= 8'h01;
      end else if ($rose(main_out)) begin
         seen_rise <= 1'b1;
         cnt <= 8'h01;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
   // tracks the output enable bit; gated outputs legally stop
   // a re-enabled output starts mid-phase, so duty waits until it is through
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_en  <= 1'b1;
         en_hist <= 3'h7;
      end else begin
         en_hist <= {en_hist[1:0], out_en};
         if (avs_write && !avs_waitrequest && avs_address == `PDSC_REG_CONTROL) begin
            out_en <= avs_writedata[0];
         end
      end
   end
   sequence req_start;
      $rose(avs_read | avs_write);
   endsequence
   sequence ref_quiet;
      (bypass && !avs_write && !load_strobe && $stable(bypass) && $stable(ref_select)
       && (ref_select ? ($stable(diff_ref_positive) && $stable(diff_ref_negative))
                      : $stable(single_ended_ref)))[*6];
   endsequence
   sequence osc_on;
      (!bypass && out_en && !load_strobe)[*8];
   endsequence
   AST_WAIT_ONE: assert property (req_start |=> !avs_waitrequest)
      else $error("no answer one cycle after request");
   AST_WAIT_SHORT: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   AST_WAIT_CAUSE: assert property (!avs_waitrequest |-> $past(avs_read | avs_write))
      else $error("answer without request");
   AST_UNMAPPED: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0
      |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   AST_INV_LEG: assert property (main_out_n == !main_out)
      else $error("inverse leg wrong");
   AST_FB_SAME: assert property (feedback_output == main_out)
      else $error("feedback output differs from main output");
   AST_DUTY: assert property ($rose(main_out) && hi_ok && !pause |-> cnt == hi_len)
      else $error("low and high lengths differ");
   AST_REF_QUIET: assert property (ref_quiet |-> $stable(main_out))
      else $error("output moved without selected reference");
   AST_OSC_RUN: assert property (osc_on |-> ##[0:300] $changed(main_out))
      else $error("oscillator path stalled");
endmodule
bind pdsc_top pdsc_checker chk_u (.clk, .rst_n, .load_strobe, .ref_select, .bypass,
   .single_ended_ref, .diff_ref_positive, .diff_ref_negative, .main_out, .main_out_n,
   .feedback_output, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
   .avs_waitrequest);
`default_nettype wire

// [verification/tb_top.sv]
// Purpose: self-checking bench of the divider control block
// Assumes: host model drives serial pins, bench drives the rest
// Notes: feedback return pair is driven only in the lock case, against the diff reference
`timescale 1ns/10ps
`default_nettype none
`include "pdsc_defs.vh"
module tb_top;
   typedef struct { logic [13:0] w; int half; } pdsc_row_t;
   logic clk, rst_n, ref_select, bypass, single_ended_ref, diff_ref_positive;
   logic diff_ref_negative, fb_p, fb_n, avs_read, avs_write;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, rd;
   wire logic load_strobe, serial_data, shift_clock, main_out, main_out_n;
   wire logic feedback_output, feedback_output_n, locked, avs_waitrequest;
   wire logic [31:0] avs_readdata;
   int mismatches = 0, check_count = 0, cyc = 0, n;
   // rows: programmed word, expected output high length in clk
   pdsc_row_t rows[5] = '{'{14'h10d1, 6}, '{14'h20fc, 7}, '{14'h3a05, 80},
                          '{14'h0154, 10}, '{14'h10ac, 5}};
   pdsc_host_model host_u (.clk, .load_strobe, .serial_data, .shift_clock);
   pdsc_top dut_u (.clk, .rst_n, .load_strobe, .serial_data, .shift_clock, .ref_select,
      .bypass, .single_ended_ref, .diff_ref_positive, .diff_ref_negative,
      .feedback_return_pos(fb_p), .feedback_return_neg(fb_n), .main_out, .main_out_n,
      .feedback_output, .feedback_output_n, .locked, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_readdata, .avs_waitrequest);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic results();
      if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected at %0t: expected %h got %h", $time, e, g);
      end
   endtask
   // ----
   // bus and measurement tasks
   // ----
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      // no loop limit: waitrequest low ends this wait, else the bench timeout
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic half_len(output int k);
      k = 0;
      for (int i = 0; i < 1000 && main_out !== 1'b0; i++) @(posedge clk);
      for (int i = 0; i < 1000 && main_out !== 1'b1; i++) @(posedge clk);
      for (int i = 0; i < 1000 && main_out === 1'b1; i++) begin
         @(posedge clk);
         k++;
      end
   endtask
   // diff reference of 8 clk; feedback return at half that rate, or held low
   task automatic lock_run(input logic fb_on);
      logic f;
      for (int i = 0; i < 480; i++) begin
         @(posedge clk);
         f = fb_on && (i % 16 >= 4) && (i % 16 < 12);
         diff_ref_positive <= (i % 8 < 4);
         diff_ref_negative <= (i % 8 >= 4);
         fb_p <= f;
         fb_n <= !f;
      end
   endtask
   // counts reference rises between two output changes, -1 if it stands
   task automatic ref_half(input logic dif, output int k);
      int ph;
      logic lvl, last;
      k = 0;
      ph = 0;
      lvl = 1'b0;
      last = main_out;
      for (int i = 0; i < 2000 && ph < 2; i++) begin
         @(posedge clk);
         if (main_out !== last) begin
            ph++;
            last = main_out;
         end
         if (i % 4 == 0) begin
            lvl = !lvl;
            if (dif) begin
               diff_ref_positive <= lvl;
               diff_ref_negative <= !lvl;
            end else single_ended_ref <= lvl;
            if (lvl && ph == 1) k++;
         end
      end
      if (ph < 2) k = -1;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         mismatches++;
         results();
      end
   end
   initial begin
      {rst_n, bypass, single_ended_ref, diff_ref_positive, fb_p, fb_n} = 6'h00;
      {ref_select, diff_ref_negative, avs_read, avs_write} = 4'h8;
      {diff_ref_negative, avs_address, avs_writedata} = {1'b1, 4'h0, 32'h0};
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      bus(0, `PDSC_REG_CONFIG, 0); check(32'h00ac, rd);
      bus(0, `PDSC_REG_CONTROL, 0); check(32'h1, rd);
      bus(1, `PDSC_REG_CONFIG, 32'h3fff); bus(0, `PDSC_REG_CONFIG, 0); check(32'h00ac, rd);
      bus(0, 4'h2, 0); check(32'h0, rd);
      foreach (rows[r]) begin
         host_u.send_word(rows[r].w);
         host_u.set_load(1'b1);
         host_u.set_load(1'b0);
         bus(0, `PDSC_REG_CONFIG, 0); check({18'h0, rows[r].w}, rd);
         half_len(n); check(rows[r].half, n);
      end
      // out code 5: bypass skips the pre-divider, five reference rises per half period
      bypass <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         ref_select <= k[1];
         ref_half(k[0], n); check((k[0] == k[1]) ? 5 : -1, n);
      end
      bypass <= 1'b0;
      // pre code 01 halves the reference, so it pairs with feedback at half its rate
      bus(1, `PDSC_REG_CONTROL, 32'h3);
      lock_run(1'b1); check(32'h1, {31'h0, locked});
      bus(0, `PDSC_REG_STATUS, 0); check(32'h29, rd & 32'hffff_fffd);
      lock_run(1'b0); check(32'h0, {31'h0, locked});
      host_u.shift_bit(1'b1);
      host_u.shift_bit(1'b0);
      host_u.shift_bit(1'b1);
      bus(0, `PDSC_REG_CONFIG, 0); check(32'h10ac, rd);
      bus(0, `PDSC_REG_SHIFT, 0); check(32'h0565, rd);
      host_u.set_load(1'b1);
      host_u.shift_bit(1'b1);
      bus(0, `PDSC_REG_CONFIG, 0); check(32'h0acb, rd);
      host_u.set_load(1'b0);
      bus(1, `PDSC_REG_CONTROL, 0);
      repeat (4) @(posedge clk);
      check(32'ha, {28'h0, feedback_output_n, feedback_output, main_out_n, main_out});
      bus(0, `PDSC_REG_CONTROL, 0); check(32'h0, rd);
      bus(1, `PDSC_REG_CONTROL, 32'h1);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      bus(0, `PDSC_REG_CONFIG, 0); check(32'h00ac, rd);
      results();
   end
endmodule
`default_nettype wire
